// ### core/stg_params.svh
// register offsets, reset values and field positions of the trigger and status block
`ifndef STG_PARAMS_SVH
`define STG_PARAMS_SVH

// byte addresses on the 32-bit register bus
`define STG_ADR_CTRL      8'h00
`define STG_ADR_CMD       8'h04
`define STG_ADR_OPER_COND 8'h08
`define STG_ADR_OPER_PTR  8'h0C
`define STG_ADR_OPER_NTR  8'h10
`define STG_ADR_OPER_EVT  8'h14
`define STG_ADR_OPER_ENA  8'h18
`define STG_ADR_STD_EVT   8'h1C
`define STG_ADR_STD_ENA   8'h20
`define STG_ADR_SUMMARY   8'h24

// operation condition bit positions
`define STG_BIT_TRAN_BUSY 6
`define STG_BIT_TRAN_WTG  7
// status byte bit driven by the operation summary
`define STG_BIT_OPER_SUM  7
// standard event summary placed in status byte bit 5
`define STG_BIT_ESB_SUM   5
// cmd register bits
`define STG_CMD_ARM       0
`define STG_CMD_TRIG      1
`define STG_CMD_GROUP     2
`define STG_CMD_ABORT     3
// ctrl register bits
`define STG_CTRL_SRC      0

`define STG_PTR_RST       16'hFFFF
`define STG_NTR_RST       16'h0000
`define STG_ENA_RST       16'h0000
`define STG_STD_ENA_RST   8'h00

`endif

// ### core/stg_pkg.sv
// types shared by the trigger and status block
package stg_pkg;
    typedef enum logic {
        STG_SRC_BUS,
        STG_SRC_NO_WAIT
    } stg_src_t;

    typedef enum logic [1:0] {
        STG_IDLE,
        STG_WAIT,
        STG_RUN
    } stg_state_t;
endpackage : stg_pkg

// ### core/stg_top.sv
// trigger state machine and status register groups behind a wishbone slave
// How it works
// - arm command in idle leaves idle and starts the trigger function, unless an abort comes in the same cycle
// - bus source: after arm, wait for trigger or abort
// - waiting: own trigger or group trigger starts the sequence
// - no_wait source: sequence starts right after arm, skipping waiting
// - sequence done returns to idle; new arm needed
// - abort while waiting or running cancels and returns idle
// - group trigger fires every armed trigger subsystem in one cycle
// - after completion outputs keep the final step's values, output keeps the last step's on/off state
// - condition register follows state bits live; reads have no side effect
// - event bit sets on a condition transition passed by its filter
// - event bits hold until the event register is read; read clears all
// - enable mask gates events; only enabled bits form the summary
// - enable register is writable and readable at any time
// - rising filter bit lets false-to-true changes set the event
// - falling filter bit lets true-to-false changes set the event
// - both filters: every change recorded; neither: nothing recorded
// - standard event group has only event and enable registers
// - OR of enabled operation events drives status byte bit 7
// - condition bit 128 shows waiting, bit 64 shows running
`timescale 1ns/1ps
`include "stg_params.svh"

module stg_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // classic wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // decoded commands from the command interpreter
    input  wire logic        sequence_arm_cmd_i,
    input  wire logic        seq_trig_cmd_i,
    input  wire logic        group_trig_cmd_i,
    input  wire logic        abort_cmd_i,
    // sequencer handshake
    input  wire logic        seq_done_i,
    input  wire logic [13:0] oper_cond_ext_i,
    input  wire logic [7:0]  std_event_i,
    input  wire logic        step_out_on_i,
    output logic             seq_start_o,
    output logic             seq_cancel_o,
    output logic             out_on_o,
    output logic             oper_summary_o,
    output logic             std_summary_o,
    output logic [7:0]       status_byte_o
);

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    logic        req;
    logic        wr;
    logic        rd;
    logic        wr_ctrl;
    logic        wr_cmd;
    logic        wr_ptr;
    logic        wr_ntr;
    logic        wr_ena;
    logic        wr_std_ena;
    logic        rd_evt;
    logic        rd_std_evt;
    logic        ack_q;

    // single-cycle answer: ack one cycle after stb, dropped next cycle
    assign req        = cyc_i && stb_i && !ack_q;
    assign wr         = req && we_i && sel_i[0];
    assign rd         = req && !we_i;
    assign wr_ctrl    = wr && hit(adr_i, `STG_ADR_CTRL);
    assign wr_cmd     = wr && hit(adr_i, `STG_ADR_CMD);
    assign wr_ptr     = wr && hit(adr_i, `STG_ADR_OPER_PTR);
    assign wr_ntr     = wr && hit(adr_i, `STG_ADR_OPER_NTR);
    assign wr_ena     = wr && hit(adr_i, `STG_ADR_OPER_ENA);
    assign wr_std_ena = wr && hit(adr_i, `STG_ADR_STD_ENA);
    assign rd_evt     = rd && hit(adr_i, `STG_ADR_OPER_EVT);
    assign rd_std_evt = rd && hit(adr_i, `STG_ADR_STD_EVT);

    // 16-bit fields written with the two low byte lanes
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    // ----------------------------------------------------------------
    // trigger state machine
    // ----------------------------------------------------------------
    stg_pkg::stg_state_t state_q;
    stg_pkg::stg_state_t state_d;
    stg_pkg::stg_src_t   src_q;
    logic                arm;
    logic                trig;
    logic                group;
    logic                abort_any;
    logic                start_d;
    logic                cancel_d;

    assign arm       = sequence_arm_cmd_i || (wr_cmd && dat_i[`STG_CMD_ARM]);
    // group trigger reaches every armed subsystem in the same cycle
    assign group     = group_trig_cmd_i || (wr_cmd && dat_i[`STG_CMD_GROUP]);
    assign trig      = seq_trig_cmd_i || (wr_cmd && dat_i[`STG_CMD_TRIG]) || group;
    assign abort_any = abort_cmd_i || (wr_cmd && dat_i[`STG_CMD_ABORT]);

    always_comb begin
        state_d  = state_q;
        start_d  = 1'b0;
        cancel_d = 1'b0;
        unique case (state_q)
            stg_pkg::STG_IDLE: begin
                // triggers here are dropped: nothing is armed
                if (arm && !abort_any) begin
                    if (src_q == stg_pkg::STG_SRC_NO_WAIT) begin
                        state_d = stg_pkg::STG_RUN;
                        start_d = 1'b1;
                    end else begin
                        state_d = stg_pkg::STG_WAIT;
                    end
                end
            end
            stg_pkg::STG_WAIT: begin
                if (abort_any) begin
                    state_d  = stg_pkg::STG_IDLE;
                    cancel_d = 1'b1;
                end else if (trig) begin
                    state_d = stg_pkg::STG_RUN;
                    start_d = 1'b1;
                end
            end
            stg_pkg::STG_RUN: begin
                if (abort_any) begin
                    state_d  = stg_pkg::STG_IDLE;
                    cancel_d = 1'b1;
                end else if (seq_done_i) begin
                    state_d = stg_pkg::STG_IDLE;
                end
            end
            default: state_d = stg_pkg::STG_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q      <= stg_pkg::STG_IDLE;
            seq_start_o  <= 1'b0;
            seq_cancel_o <= 1'b0;
        end else begin
            state_q      <= state_d;
            seq_start_o  <= start_d;
            seq_cancel_o <= cancel_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_q <= stg_pkg::STG_SRC_BUS;
        end else if (wr_ctrl) begin
            src_q <= stg_pkg::stg_src_t'(dat_i[`STG_CTRL_SRC]);
        end
    end

    // output follows each step while running and is simply held after completion
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_on_o <= 1'b0;
        end else if (state_q == stg_pkg::STG_RUN) begin
            out_on_o <= step_out_on_i;
        end
    end

    // ----------------------------------------------------------------
    // external condition filter
    // ----------------------------------------------------------------
    // condition sources sit outside this clock: each bit passes three stages
    // and is taken only once the last two agree, at the cost of four cycles of lag
    logic [13:0] ext_s1_q;
    logic [13:0] ext_s2_q;
    logic [13:0] ext_s3_q;
    logic [13:0] ext_q;
    logic [13:0] ext_d;

    // a bit whose last two stages still disagree keeps its accepted value
    assign ext_d = (ext_s2_q & ext_s3_q) | (ext_q & (ext_s2_q ^ ext_s3_q));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_s1_q <= 14'h0000;
            ext_s2_q <= 14'h0000;
            ext_s3_q <= 14'h0000;
            ext_q    <= 14'h0000;
        end else begin
            ext_s1_q <= oper_cond_ext_i;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            ext_q    <= ext_d;
        end
    end

    // ----------------------------------------------------------------
    // operation status group
    // ----------------------------------------------------------------
    logic [15:0] cond_q;
    logic [15:0] cond_d;
    logic [15:0] ptr_q;
    logic [15:0] ntr_q;
    logic [15:0] evt_q;
    logic [15:0] ena_q;
    logic [15:0] rise;
    logic [15:0] fall;
    logic [15:0] new_evt;
    logic        oper_sum;

    // live condition: trigger bits from the machine, the rest from outside
    assign cond_d = {ext_q[13:6],
                     state_q == stg_pkg::STG_WAIT,
                     state_q == stg_pkg::STG_RUN,
                     ext_q[5:0]};

    generate
        for (genvar i = 0; i < 16; i++) begin : g_filt
            assign rise[i]    = cond_d[i] && !cond_q[i];
            assign fall[i]    = !cond_d[i] && cond_q[i];
            // both filters record every change, neither records nothing
            assign new_evt[i] = (rise[i] && ptr_q[i])
                              || (fall[i] && ntr_q[i]);
        end
    endgenerate

    assign oper_sum = |(evt_q & ena_q);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cond_q <= 16'h0000;
        end else begin
            cond_q <= cond_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ptr_q <= `STG_PTR_RST;
            ntr_q <= `STG_NTR_RST;
            ena_q <= `STG_ENA_RST;
        end else begin
            if (wr_ptr) ptr_q <= merge16(ptr_q, dat_i, sel_i);
            if (wr_ntr) ntr_q <= merge16(ntr_q, dat_i, sel_i);
            if (wr_ena) ena_q <= merge16(ena_q, dat_i, sel_i);
        end
    end

    // the read clears, but a transition in the same cycle still lands
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_q <= 16'h0000;
        end else begin
            evt_q <= (rd_evt ? 16'h0000 : evt_q) | new_evt;
        end
    end

    // ----------------------------------------------------------------
    // standard event group: event and enable only
    // ----------------------------------------------------------------
    logic [7:0] std_evt_q;
    logic [7:0] std_ena_q;
    logic       std_sum;

    assign std_sum = |(std_evt_q & std_ena_q);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            std_evt_q <= 8'h00;
            std_ena_q <= `STG_STD_ENA_RST;
        end else begin
            std_evt_q <= (rd_std_evt ? 8'h00 : std_evt_q) | std_event_i;
            if (wr_std_ena) std_ena_q <= dat_i[7:0];
        end
    end

    // ----------------------------------------------------------------
    // summaries
    // ----------------------------------------------------------------
    logic [7:0] stb_d;

    always_comb begin
        stb_d                    = 8'h00;
        stb_d[`STG_BIT_OPER_SUM] = oper_sum;
        stb_d[`STG_BIT_ESB_SUM]  = std_sum;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oper_summary_o <= 1'b0;
            std_summary_o  <= 1'b0;
            status_byte_o  <= 8'h00;
        end else begin
            oper_summary_o <= oper_sum;
            std_summary_o  <= std_sum;
            status_byte_o  <= stb_d;
        end
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    logic [31:0] rdata;

    always_comb begin
        unique case (adr_i)
            `STG_ADR_CTRL:      rdata = {31'h0, src_q};
            `STG_ADR_CMD:       rdata = {30'h0, state_q};
            `STG_ADR_OPER_COND: rdata = {16'h0, cond_q};
            `STG_ADR_OPER_PTR:  rdata = {16'h0, ptr_q};
            `STG_ADR_OPER_NTR:  rdata = {16'h0, ntr_q};
            `STG_ADR_OPER_EVT:  rdata = {16'h0, evt_q};
            `STG_ADR_OPER_ENA:  rdata = {16'h0, ena_q};
            `STG_ADR_STD_EVT:   rdata = {24'h0, std_evt_q};
            `STG_ADR_STD_ENA:   rdata = {24'h0, std_ena_q};
            `STG_ADR_SUMMARY:   rdata = {24'h0, stb_d};
            default:            rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            if (rd) dat_o <= rdata;
        end
    end

    assign ack_o = ack_q;

endmodule : stg_top

// ### verification/stg_top_properties.sv
// port-level assertions for the trigger and status block
`timescale 1ns/1ps
module stg_top_properties (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       cyc_i,
    input wire logic       stb_i,
    input wire logic       ack_o,
    input wire logic       seq_start_o,
    input wire logic       seq_cancel_o,
    input wire logic       oper_summary_o,
    input wire logic       std_summary_o,
    input wire logic [7:0] status_byte_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_follows_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no ack one cycle after a request");
    a_ack_one_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_start_one_pulse: assert property (seq_start_o |=> !seq_start_o)
        else $error("start held longer than one cycle");
    a_cancel_one_pulse: assert property ($rose(seq_cancel_o) |=> !seq_cancel_o)
        else $error("cancel held longer than one cycle");
    a_start_cancel_apart: assert property (!(seq_start_o && seq_cancel_o))
        else $error("start and cancel in one cycle");
    a_oper_sum_bit: assert property (status_byte_o[7] == oper_summary_o)
        else $error("status bit 7 differs from operation summary");
    a_std_sum_bit: assert property (status_byte_o[5] == std_summary_o)
        else $error("status bit 5 differs from standard summary");
    a_status_spare_zero: assert property (status_byte_o[6] == 1'b0 && status_byte_o[4:0] == 5'h00)
        else $error("unused status byte bits not zero");
endmodule : stg_top_properties

bind stg_top stg_top_properties stg_top_properties_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .seq_start_o(seq_start_o), .seq_cancel_o(seq_cancel_o), .oper_summary_o(oper_summary_o),
    .std_summary_o(std_summary_o), .status_byte_o(status_byte_o));

// ### verification/stg_seq_model.sv
// behavioural sequencer that answers start with done after a set latency
`timescale 1ns/1ps
module stg_seq_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       seq_start_i,
    input  wire logic       seq_cancel_i,
    input  wire logic [3:0] lat_i,
    input  wire logic       last_on_i,
    output logic            seq_done_o,
    output logic            step_out_on_o
);
    logic [3:0] cnt_q;
    logic       run_q;
    always_ff @(posedge clk_i) begin
        seq_done_o <= 1'b0;
        if (rst_i || seq_cancel_i) begin
            run_q <= 1'b0;
        end else if (seq_start_i) begin
            run_q <= 1'b1;
            cnt_q <= lat_i;
        end else if (run_q && cnt_q == 4'h0) begin
            run_q      <= 1'b0;
            seq_done_o <= 1'b1;
        end else if (run_q) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end
    // the last step stays on show through the done pulse; outside a run show the inverse
    assign step_out_on_o = (run_q || seq_done_o) ? last_on_i : !last_on_i;
endmodule : stg_seq_model

// ### verification/stg_top_tb.sv
// self-checking bench for the trigger and status block
`timescale 1ns/1ps
`include "stg_params.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module stg_top_tb;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, seq_done_i, step_out_on_i, last_on;
    logic        seq_start_o, seq_cancel_o, out_on_o, oper_summary_o, std_summary_o;
    logic [7:0]  adr_i, std_event_i, status_byte_o, se, sv;
    logic [3:0]  sel_i, cmd, lat;
    logic [31:0] dat_i, dat_o, rd;
    logic [13:0] ext, xa, xb;
    logic [15:0] ptr, ntr, ena, a, b, ev;
    int          n_fail, num_checks, starts, cancels;

    stg_top stg_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .sequence_arm_cmd_i(cmd[0]), .seq_trig_cmd_i(cmd[1]), .group_trig_cmd_i(cmd[2]),
        .abort_cmd_i(cmd[3]), .seq_done_i(seq_done_i), .oper_cond_ext_i(ext),
        .std_event_i(std_event_i), .step_out_on_i(step_out_on_i), .seq_start_o(seq_start_o),
        .seq_cancel_o(seq_cancel_o), .out_on_o(out_on_o), .oper_summary_o(oper_summary_o),
        .std_summary_o(std_summary_o), .status_byte_o(status_byte_o));
    stg_seq_model stg_seq_model_i (.clk_i(clk_i), .rst_i(rst_i), .seq_start_i(seq_start_o),
        .seq_cancel_i(seq_cancel_o), .lat_i(lat), .last_on_i(last_on),
        .seq_done_o(seq_done_i), .step_out_on_o(step_out_on_i));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        starts  += (seq_start_o === 1'b1);
        cancels += (seq_cancel_o === 1'b1);
    end
    initial begin
        #(100 * 20000);
        n_fail++;
        results();
    end

    function automatic logic [15:0] cond_of(input logic [13:0] x);
        return {x[13:6], 2'b00, x[5:0]};
    endfunction : cond_of
    task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, ad, d, 4'hF};
        // only the watchdog ends a wait for the answer
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        {cyc_i, stb_i} <= 2'b00;
    endtask : wb
    task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
        wb(1'b0, ad, 32'h0);
        `CHK($sformatf("reg %h", ad), e, rd)
    endtask : rdc
    task automatic pulse(input int k);
        @(posedge clk_i);
        cmd[k] <= 1'b1;
        @(posedge clk_i);
        cmd[k] <= 1'b0;
    endtask : pulse
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, cmd} = '0;
        {ext, std_event_i, lat, last_on} = '0;
        rst_i = 1'b1;
        void'($urandom(32'hDDE8));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(`STG_ADR_OPER_PTR, 32'h0000FFFF);
        rdc(`STG_ADR_OPER_NTR, 32'h0);
        rdc(`STG_ADR_CMD, 32'h0);
        rdc(8'h3C, 32'h0);
        $display("reset test done");
        wb(1'b1, `STG_ADR_CTRL, 32'h0);
        lat <= 4'hA + 4'($urandom % 6);
        last_on <= 1'($urandom);
        pulse(1);
        pulse(2);
        repeat (3) @(posedge clk_i);
        `CHK("idle trigger starts", 0, starts)
        pulse(0);
        rdc(`STG_ADR_CMD, 32'h1);
        rdc(`STG_ADR_OPER_COND, 32'h80);
        pulse(2);
        rdc(`STG_ADR_CMD, 32'h2);
        `CHK("group trigger starts", 1, starts)
        rdc(`STG_ADR_OPER_COND, 32'h40);
        repeat (20) @(posedge clk_i);
        rdc(`STG_ADR_CMD, 32'h0);
        `CHK("held output", last_on, out_on_o)
        pulse(1);
        repeat (3) @(posedge clk_i);
        `CHK("trigger after done", 1, starts)
        $display("bus source test done");
        wb(1'b1, `STG_ADR_CTRL, 32'h1);
        lat <= 4'hF;
        pulse(0);
        rdc(`STG_ADR_CMD, 32'h2);
        pulse(3);
        rdc(`STG_ADR_CMD, 32'h0);
        `CHK("run cancels", 1, cancels)
        wb(1'b1, `STG_ADR_CTRL, 32'h0);
        pulse(0);
        pulse(3);
        rdc(`STG_ADR_CMD, 32'h0);
        `CHK("abort starts", 2, starts)
        `CHK("wait cancels", 2, cancels)
        $display("abort test done");
        wb(1'b1, `STG_ADR_CMD, 32'h1 << `STG_CMD_ARM);
        rdc(`STG_ADR_CMD, 32'h1);
        pulse(1);
        rdc(`STG_ADR_CMD, 32'h2);
        wb(1'b1, `STG_ADR_CMD, 32'h1 << `STG_CMD_ABORT);
        rdc(`STG_ADR_CMD, 32'h0);
        wb(1'b1, `STG_ADR_CMD, (32'h1 << `STG_CMD_ARM) | (32'h1 << `STG_CMD_ABORT));
        rdc(`STG_ADR_CMD, 32'h0);
        wb(1'b1, `STG_ADR_CMD, 32'h1 << `STG_CMD_ARM);
        wb(1'b1, `STG_ADR_CMD, 32'h1 << `STG_CMD_TRIG);
        rdc(`STG_ADR_CMD, 32'h2);
        pulse(3);
        rdc(`STG_ADR_CMD, 32'h0);
        `CHK("command starts", 4, starts)
        `CHK("command cancels", 4, cancels)
        $display("command register test done");
        for (int i = 0; i < 6; i++) begin
            {ptr, ntr, ena, xa, xb, se, sv} = 92'({$urandom, $urandom, $urandom});
            if (i == 0) {ptr, ntr} = 32'hFFFFFFFF;
            if (i == 1) {ptr, ntr} = 32'h0;
            wb(1'b1, `STG_ADR_OPER_PTR, {16'h0, ptr});
            wb(1'b1, `STG_ADR_OPER_NTR, {16'h0, ntr});
            wb(1'b1, `STG_ADR_OPER_ENA, {16'h0, ena});
            rdc(`STG_ADR_OPER_ENA, {16'h0, ena});
            ext <= xa;
            repeat (4) @(posedge clk_i);
            wb(1'b0, `STG_ADR_OPER_EVT, 32'h0);
            wb(1'b0, `STG_ADR_STD_EVT, 32'h0);
            ext <= xb;
            std_event_i <= sv;
            @(posedge clk_i);
            std_event_i <= 8'h00;
            wb(1'b1, `STG_ADR_STD_ENA, {24'h0, se});
            repeat (4) @(posedge clk_i);
            #1;
            {a, b} = {cond_of(xa), cond_of(xb)};
            ev = (~a & b & ptr) | (a & ~b & ntr);
            `CHK("operation summary", |(ev & ena), oper_summary_o)
            `CHK("status bit 7", |(ev & ena), status_byte_o[7])
            `CHK("standard summary", |(sv & se), std_summary_o)
            `CHK("status byte", ({|(ev & ena), 1'b0, |(sv & se), 5'h00}), status_byte_o)
            rdc(`STG_ADR_OPER_COND, {16'h0, b});
            rdc(`STG_ADR_OPER_EVT, {16'h0, ev});
            rdc(`STG_ADR_OPER_EVT, 32'h0);
            rdc(`STG_ADR_STD_ENA, {24'h0, se});
            rdc(`STG_ADR_STD_EVT, {24'h0, sv});
            rdc(`STG_ADR_STD_EVT, 32'h0);
        end
        // condition lag is four cycles, so this change reaches the event register
        // at the very edge that takes the read below
        wb(1'b1, `STG_ADR_OPER_PTR, 32'h0000FFFF);
        wb(1'b1, `STG_ADR_OPER_NTR, 32'h0000FFFF);
        ext <= ~xb;
        repeat (3) @(posedge clk_i);
        wb(1'b0, `STG_ADR_OPER_EVT, 32'h0);
        `CHK("event read in transition", 32'h0, rd)
        rdc(`STG_ADR_OPER_EVT, {16'h0, cond_of(~xb) ^ cond_of(xb)});
        $display("status test done");
        results();
    end
endmodule : stg_top_tb
